// ==== verilog/calsr_map.svh ====
`ifndef CALSR_MAP_SVH
`define CALSR_MAP_SVH

// ==========================================================
// register byte offsets
`define CALSR_OFF_CMD 8'h00
`define CALSR_OFF_ERR_RAISE 8'h04
`define CALSR_OFF_SRE 8'h08
`define CALSR_OFF_ESE 8'h0c
`define CALSR_OFF_STB 8'h10
`define CALSR_OFF_ESR 8'h14
`define CALSR_OFF_ERRQ 8'h18
`define CALSR_OFF_OUTQ 8'h1c
`define CALSR_OFF_STATUS 8'h20
`define CALSR_OFF_CTRL 8'h24
`define CALSR_OFF_AC_CONST 8'h28

// ==========================================================
// reset values
`define CALSR_SRE_RST 8'h00
`define CALSR_ESE_RST 8'h00
`define CALSR_ESR_RST 8'h00

// ==========================================================
// status byte and event register bit positions
`define CALSR_STB_ERROR_AVAILABLE_FLAG 2
`define CALSR_STB_MESSAGE_AVAILABLE_FLAG 4
`define CALSR_STB_EVENT_SUMMARY_FLAG 5
`define CALSR_STB_RQS 6
`define CALSR_ESR_OPC 0
`define CALSR_ESR_DDE 3
`define CALSR_ESR_EXE 4
`define CALSR_ESR_CME 5
`define CALSR_RQS_MASK 8'h40
`define CALSR_OPC_ONE 8'h31

// ==========================================================
// error codes, 16-bit two's complement
`define CALSR_ERR_NONE 16'h0000
`define CALSR_ERR_SYNTAX 16'hff9a
`define CALSR_ERR_HEADER 16'hff8f
`define CALSR_ERR_EXEC 16'hff38
`define CALSR_ERR_LOCKED 16'hff23
`define CALSR_ERR_PARAM 16'hff22
`define CALSR_ERR_NO_DATE 16'h01b6
`define CALSR_ERR_NO_NEXT 16'h01b7
`define CALSR_ERR_INCOMPLETE 16'h01b8

// ==========================================================
// error queue
`define CALSR_ERRQ_DEPTH 8
`define CALSR_ERRQ_FULL 4'h8

// ==========================================================
// timing
`define CALSR_CLK_NS 20
`define CALSR_AC_CAL_NS 50000
`define CALSR_STEP_NS 20000
`define CALSR_AC_CAL_CYC ((`CALSR_AC_CAL_NS + `CALSR_CLK_NS - 1) / `CALSR_CLK_NS)
`define CALSR_STEP_CYC ((`CALSR_STEP_NS + `CALSR_CLK_NS - 1) / `CALSR_CLK_NS)

`endif

// ==== verilog/calsr_pkg.sv ====
`include "calsr_map.svh"

package calsr_pkg;

  // ==========================================================
  // command opcodes
  typedef enum logic [3:0] {
    op_none = 4'b0000,
    op_ac_self_calibrate = 4'b0001,
    op_cal_step = 4'b0010,
    op_cal_calc = 4'b0011,
    op_opc_query = 4'b0100,
    op_opc_cmd = 4'b0101,
    op_clear_status = 4'b0110,
    op_stb_query = 4'b0111,
    op_esr_query = 4'b1000
  } calsr_op_t;

  // ==========================================================
  // error kinds raised by the command parser
  typedef enum logic [2:0] {
    kind_none = 3'b000,
    kind_syntax = 3'b001,
    kind_header = 3'b010,
    kind_param = 3'b011,
    kind_no_date = 3'b100,
    kind_no_next_date = 3'b101,
    kind_incomplete = 3'b110
  } calsr_kind_t;

  typedef enum logic [1:0] {
    eng_idle = 2'b00,
    eng_ac = 2'b01,
    eng_step = 2'b10
  } calsr_eng_t;

  function automatic logic [15:0] calsr_kind_code(input calsr_kind_t k);
    case (k)
      kind_syntax: calsr_kind_code = `CALSR_ERR_SYNTAX;
      kind_header: calsr_kind_code = `CALSR_ERR_HEADER;
      kind_param: calsr_kind_code = `CALSR_ERR_PARAM;
      kind_no_date: calsr_kind_code = `CALSR_ERR_NO_DATE;
      kind_no_next_date: calsr_kind_code = `CALSR_ERR_NO_NEXT;
      kind_incomplete: calsr_kind_code = `CALSR_ERR_INCOMPLETE;
      default: calsr_kind_code = `CALSR_ERR_NONE;
    endcase
  endfunction

  // event bit that an error class sets: -1xx command, -2xx execution, +4xx device
  function automatic logic [7:0] calsr_err_esr(input logic [15:0] code);
    calsr_err_esr = 8'h00;
    if (!code[15]) begin
      calsr_err_esr[`CALSR_ESR_DDE] = 1'b1;
    end else if ($signed(code) > $signed(`CALSR_ERR_EXEC)) begin
      calsr_err_esr[`CALSR_ESR_CME] = 1'b1;
    end else begin
      calsr_err_esr[`CALSR_ESR_EXE] = 1'b1;
    end
  endfunction

endpackage

// ==== verilog/calsr_errq.sv ====
`timescale 1ns/1ps
`include "calsr_map.svh"

module calsr_errq import calsr_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic push,
  input wire logic [15:0] push_code,
  input wire logic pop,
  input wire logic clr,
  // state
  output logic [15:0] head,
  output logic empty
);

  typedef struct packed {
    logic [`CALSR_ERRQ_DEPTH-1:0][15:0] mem;
    logic [2:0] wp;
    logic [2:0] rp;
    logic [3:0] cnt;
  } calsr_errq_state_t;

  calsr_errq_state_t q_reg;
  calsr_errq_state_t q_next;

  // ==========================================================
  // next state
  always_comb begin
    q_next = q_reg;
    if (clr) begin
      q_next.wp = 3'h0;
      q_next.rp = 3'h0;
      q_next.cnt = 4'h0;
    end else if (pop && q_reg.cnt != 4'h0) begin
      q_next.rp = q_reg.rp + 3'h1;
      q_next.cnt = q_reg.cnt - 4'h1;
    end
    // a full queue keeps its oldest entries and drops the newcomer
    if (push && q_next.cnt != `CALSR_ERRQ_FULL) begin
      q_next.mem[q_next.wp] = push_code;
      q_next.wp = q_next.wp + 3'h1;
      q_next.cnt = q_next.cnt + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign empty = (q_reg.cnt == 4'h0);
  assign head = empty ? `CALSR_ERR_NONE : q_reg.mem[q_reg.rp];

endmodule

// ==== verilog/calsr_cal_eng.sv ====
`timescale 1ns/1ps
`include "calsr_map.svh"

module calsr_cal_eng import calsr_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // launch
  input wire logic start_ac,
  input wire logic start_step,
  // state
  output logic busy,
  output logic done,
  output logic [15:0] ac_const,
  output logic ac_valid
);

  typedef struct packed {
    calsr_eng_t mode;
    logic [11:0] cnt;
    logic [15:0] lfsr;
    logic [15:0] ac_const;
    logic ac_valid;
    logic done;
  } calsr_eng_state_t;

  localparam logic [11:0] AC_LAST = 12'(`CALSR_AC_CAL_CYC - 1);
  localparam logic [11:0] STEP_LAST = 12'(`CALSR_STEP_CYC - 1);

  calsr_eng_state_t e_reg;
  calsr_eng_state_t e_next;

  // ==========================================================
  // next state
  always_comb begin
    e_next = e_reg;
    e_next.done = 1'b0;
    // stands in for the internal reference measurement
    e_next.lfsr = {e_reg.lfsr[14:0], e_reg.lfsr[15] ^ e_reg.lfsr[13] ^ e_reg.lfsr[12]
                   ^ e_reg.lfsr[10] ^ 1'b1};
    case (e_reg.mode)
      eng_idle: begin
        if (start_ac) begin
          e_next.mode = eng_ac;
          e_next.cnt = AC_LAST;
        end else if (start_step) begin
          e_next.mode = eng_step;
          e_next.cnt = STEP_LAST;
        end
      end
      eng_ac, eng_step: begin
        if (e_reg.cnt == 12'h000) begin
          e_next.done = 1'b1;
          e_next.mode = eng_idle;
          if (e_reg.mode == eng_ac) begin
            // volatile only: lost at reset, never written to lasting storage
            e_next.ac_const = e_reg.lfsr;
            e_next.ac_valid = 1'b1;
          end
        end else begin
          e_next.cnt = e_reg.cnt - 12'h001;
        end
      end
      default: begin
        e_next.mode = eng_idle;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      e_reg <= '0;
    end else begin
      e_reg <= e_next;
    end
  end

  assign busy = (e_reg.mode != eng_idle);
  assign done = e_reg.done;
  assign ac_const = e_reg.ac_const;
  assign ac_valid = e_reg.ac_valid;

endmodule

// ==== verilog/calsr_top.sv ====
// Overview of operation
// - AC self-calibrate keeps constants volatile only
// - calibration errors enter error queue while it holds fewer than 8
// - error available flag while queue nonempty
// - error read returns and removes oldest entry
// - enable value 4 raises service request
// - completion query answers ASCII one
// - message available flag while response waits
// - event enable 1 routes completion
// - event summary flag from enabled events
// - appended completion command records event
// - event register read returns and clears
// - clear-status empties queue and events
// - codes 0, -102, -113, -222
// - codes -200 sequence, -221 locked
// - codes +438, +439, +440
// - status byte by query and poll
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "calsr_map.svh"

module calsr_top import calsr_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // bus side pins
  input wire logic spoll_req_pin,
  output logic srq,
  output logic [7:0] spoll_byte,
  output logic spoll_strobe
);

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [7:0] sre;
    logic [7:0] ese;
    logic [7:0] esr;
    logic [7:0] outq;
    logic message_available_flag;
    logic opcq_pend;
    logic opc_pend;
    logic cal_lock;
    logic steps_done;
    logic srq;
    logic sp_meta;
    logic sp_sync;
    logic sp_prev;
    logic [7:0] spoll_byte;
    logic spoll_strobe;
  } calsr_top_state_t;

  calsr_top_state_t r_reg;
  calsr_top_state_t r_next;

  // submodule wires
  logic eq_push;
  logic [15:0] eq_code;
  logic eq_pop;
  logic eq_clr;
  logic [15:0] eq_head;
  logic eq_empty;
  logic start_ac;
  logic start_step;
  logic eng_busy;
  logic [15:0] ac_const;
  logic ac_valid;

  // ==========================================================
  // status byte assembly, shared by register read, query and poll
  function automatic logic [7:0] build_stb(input logic err_avail, input logic msg_avail,
                                           input logic evt_sum, input logic rqs);
    build_stb = 8'h00;
    build_stb[`CALSR_STB_ERROR_AVAILABLE_FLAG] = err_avail;
    build_stb[`CALSR_STB_MESSAGE_AVAILABLE_FLAG] = msg_avail;
    build_stb[`CALSR_STB_EVENT_SUMMARY_FLAG] = evt_sum;
    build_stb[`CALSR_STB_RQS] = rqs;
  endfunction

  // ==========================================================
  // submodules
  calsr_errq u_errq (
    .pclk(pclk),
    .presetn(presetn),
    .push(eq_push),
    .push_code(eq_code),
    .pop(eq_pop),
    .clr(eq_clr),
    .head(eq_head),
    .empty(eq_empty)
  );

  calsr_cal_eng u_eng (
    .pclk(pclk),
    .presetn(presetn),
    .start_ac(start_ac),
    .start_step(start_step),
    .busy(eng_busy),
    .done(),
    .ac_const(ac_const),
    .ac_valid(ac_valid)
  );

  // ==========================================================
  // next state
  always_comb begin
    logic setup;
    logic acc_wr;
    logic acc_rd;
    logic event_summary_flag;
    logic [7:0] stb_cur;
    logic [7:0] esr_set;
    logic esr_clr;
    logic put;
    logic [7:0] put_val;
    logic take;
    logic raise;
    logic [15:0] raise_code;
    calsr_op_t op;

    setup = 1'b0;
    acc_wr = 1'b0;
    acc_rd = 1'b0;
    event_summary_flag = 1'b0;
    stb_cur = 8'h00;
    esr_set = 8'h00;
    esr_clr = 1'b0;
    put = 1'b0;
    put_val = 8'h00;
    take = 1'b0;
    raise = 1'b0;
    raise_code = `CALSR_ERR_NONE;
    op = calsr_op_t'(pwdata[3:0]);
    r_next = r_reg;
    eq_pop = 1'b0;
    eq_clr = 1'b0;
    start_ac = 1'b0;
    start_step = 1'b0;

    event_summary_flag = |(r_reg.esr & r_reg.ese);
    stb_cur = build_stb(!eq_empty, r_reg.message_available_flag, event_summary_flag,
                        r_reg.srq);

    // no wait state: ready and read data leave flip-flops loaded in the setup cycle
    setup = psel && !penable && !r_reg.pready;
    r_next.pready = psel && !r_reg.pready;
    acc_wr = psel && penable && r_reg.pready && pwrite && !r_reg.pslverr;
    acc_rd = psel && penable && r_reg.pready && !pwrite && !r_reg.pslverr;

    // ========================================================
    // address decode in the setup cycle
    if (setup) begin
      r_next.pslverr = 1'b0;
      r_next.prdata = 32'h0000_0000;
      case (paddr)
        `CALSR_OFF_CMD, `CALSR_OFF_ERR_RAISE: r_next.prdata = 32'h0000_0000;
        `CALSR_OFF_SRE: r_next.prdata = {24'h00_0000, r_reg.sre};
        `CALSR_OFF_ESE: r_next.prdata = {24'h00_0000, r_reg.ese};
        `CALSR_OFF_STB: r_next.prdata = {24'h00_0000, stb_cur};
        `CALSR_OFF_ESR: r_next.prdata = {24'h00_0000, r_reg.esr};
        `CALSR_OFF_ERRQ: r_next.prdata = {{16{eq_head[15]}}, eq_head};
        `CALSR_OFF_OUTQ: r_next.prdata = {24'h00_0000, r_reg.outq};
        `CALSR_OFF_STATUS: begin
          r_next.prdata = {28'h000_0000, r_reg.steps_done, r_reg.cal_lock,
                           ac_valid, eng_busy};
        end
        `CALSR_OFF_CTRL: r_next.prdata = {31'h0000_0000, r_reg.cal_lock};
        `CALSR_OFF_AC_CONST: r_next.prdata = {16'h0000, ac_const};
        default: r_next.pslverr = 1'b1;
      endcase
    end else if (!psel) begin
      r_next.pslverr = 1'b0;
    end

    // ========================================================
    // read side effects at the completing edge
    if (acc_rd) begin
      case (paddr)
        `CALSR_OFF_ERRQ: eq_pop = 1'b1;
        `CALSR_OFF_ESR: esr_clr = 1'b1;
        `CALSR_OFF_OUTQ: take = 1'b1;
        default: ;
      endcase
    end

    // ========================================================
    // writes and commands
    if (acc_wr) begin
      case (paddr)
        `CALSR_OFF_CMD: begin
          case (op)
            op_none: ;
            op_ac_self_calibrate: begin
              if (eng_busy) begin
                // a command while the engine runs, AC or step, breaks the expected sequence
                raise = 1'b1;
                raise_code = `CALSR_ERR_EXEC;
              end else begin
                start_ac = 1'b1;
              end
            end
            op_cal_step: begin
              if (r_reg.cal_lock) begin
                raise = 1'b1;
                raise_code = `CALSR_ERR_LOCKED;
              end else if (eng_busy) begin
                raise = 1'b1;
                raise_code = `CALSR_ERR_EXEC;
              end else begin
                start_step = 1'b1;
                r_next.steps_done = 1'b1;
              end
            end
            op_cal_calc: begin
              if (r_reg.cal_lock) begin
                raise = 1'b1;
                raise_code = `CALSR_ERR_LOCKED;
              end else if (eng_busy) begin
                raise = 1'b1;
                raise_code = `CALSR_ERR_EXEC;
              end else if (!r_reg.steps_done) begin
                raise = 1'b1;
                raise_code = `CALSR_ERR_INCOMPLETE;
              end else begin
                r_next.steps_done = 1'b0;
              end
            end
            op_opc_query: r_next.opcq_pend = 1'b1;
            op_opc_cmd: r_next.opc_pend = 1'b1;
            op_clear_status: begin
              esr_clr = 1'b1;
              eq_clr = 1'b1;
              r_next.opc_pend = 1'b0;
              r_next.opcq_pend = 1'b0;
            end
            op_stb_query: begin
              put = 1'b1;
              put_val = stb_cur;
            end
            op_esr_query: begin
              put = 1'b1;
              put_val = r_reg.esr;
              esr_clr = 1'b1;
            end
            default: begin
              raise = 1'b1;
              raise_code = `CALSR_ERR_HEADER;
            end
          endcase
        end
        `CALSR_OFF_ERR_RAISE: begin
          raise_code = calsr_kind_code(calsr_kind_t'(pwdata[2:0]));
          raise = (raise_code != `CALSR_ERR_NONE);
        end
        // the request bit of the status byte is not maskable
        `CALSR_OFF_SRE: r_next.sre = pwdata[7:0] & ~`CALSR_RQS_MASK;
        `CALSR_OFF_ESE: r_next.ese = pwdata[7:0];
        `CALSR_OFF_CTRL: r_next.cal_lock = pwdata[0];
        default: begin
        end
      endcase
    end

    // ========================================================
    // completion reporting: only once the engine is truly idle
    if (!eng_busy && !start_ac && !start_step) begin
      if (r_reg.opcq_pend && !put) begin
        put = 1'b1;
        put_val = `CALSR_OPC_ONE;
        r_next.opcq_pend = 1'b0;
      end
      if (r_reg.opc_pend) begin
        esr_set[`CALSR_ESR_OPC] = 1'b1;
        r_next.opc_pend = 1'b0;
      end
    end

    // ========================================================
    // errors, event register and output queue; sets win over clears
    eq_push = raise;
    eq_code = raise_code;
    if (raise) begin
      esr_set = esr_set | calsr_err_esr(raise_code);
    end
    r_next.esr = (esr_clr ? `CALSR_ESR_RST : r_reg.esr) | esr_set;
    if (take) begin
      r_next.message_available_flag = 1'b0;
    end
    if (put) begin
      r_next.outq = put_val;
      r_next.message_available_flag = 1'b1;
    end

    // request follows enabled flags, so it drops when they clear
    r_next.srq = |(stb_cur & r_reg.sre & ~`CALSR_RQS_MASK);

    // ========================================================
    // serial poll; only the second stage feeds the edge detect
    r_next.sp_meta = spoll_req_pin;
    r_next.sp_sync = r_reg.sp_meta;
    r_next.sp_prev = r_reg.sp_sync;
    r_next.spoll_strobe = r_reg.sp_sync && !r_reg.sp_prev;
    if (r_reg.sp_sync && !r_reg.sp_prev) begin
      r_next.spoll_byte = stb_cur;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================
  // outputs
  assign prdata = r_reg.prdata;
  assign pready = r_reg.pready;
  assign pslverr = r_reg.pslverr;
  assign srq = r_reg.srq;
  assign spoll_byte = r_reg.spoll_byte;
  assign spoll_strobe = r_reg.spoll_strobe;

endmodule

// ==== tb/calsr_top_props.sv ====
`timescale 1ns/1ps
`include "calsr_map.svh"

module calsr_top_props (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // bus side pins
  input wire logic spoll_req_pin,
  input wire logic srq,
  input wire logic [7:0] spoll_byte,
  input wire logic spoll_strobe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================================
  // apb timing
  AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_READY_IDLE: assert property (!psel |=> !pready)
    else $error("ready without select");
  AST_ERR_UNMAPPED: assert property (pready && (paddr[1:0] != 2'h0 ||
    paddr > `CALSR_OFF_AC_CONST) |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_OK_MAPPED: assert property (pready && paddr[1:0] == 2'h0 &&
    paddr <= `CALSR_OFF_AC_CONST |-> !pslverr)
    else $error("mapped access refused");

  // ==========================================================
  // status byte and error codes
  AST_STB_LAYOUT: assert property (pready && !pwrite && paddr == `CALSR_OFF_STB |->
    prdata[31:7] == 25'h0 && !prdata[3] && prdata[1:0] == 2'h0)
    else $error("status byte has stray bits");
  AST_ERRQ_SIGN: assert property (pready && !pwrite && paddr == `CALSR_OFF_ERRQ |->
    prdata[31:16] == {16{prdata[15]}})
    else $error("error code not sign extended");

  // ==========================================================
  // serial poll
  AST_POLL_LATENCY: assert property ($rose(spoll_req_pin) |-> ##[2:4] spoll_strobe)
    else $error("serial poll not answered");
  AST_STROBE_ONE: assert property (spoll_strobe |=> !spoll_strobe)
    else $error("poll strobe too long");
  AST_BYTE_HOLD: assert property ($changed(spoll_byte) |-> spoll_strobe)
    else $error("poll byte changed without poll");
endmodule

bind calsr_top calsr_top_props calsr_top_props_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .spoll_req_pin(spoll_req_pin),
  .srq(srq), .spoll_byte(spoll_byte), .spoll_strobe(spoll_strobe));

// ==== tb/calsr_host_model.sv ====
`timescale 1ns/1ps

module calsr_host_model (
  // clock
  input wire logic pclk,
  // poll pins
  output logic spoll_req_pin,
  input wire logic spoll_strobe,
  input wire logic [7:0] spoll_byte
);
  // pin low from time zero: a stray edge after reset would fake a poll
  initial spoll_req_pin = 1'b0;

  // ==========================================================
  // one serial poll, waiting for the strobe under a bound
  task automatic poll(output logic [7:0] b);
    int n;
    n = 0;
    @(posedge pclk);
    spoll_req_pin <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (spoll_strobe !== 1'b1 && n < 8);
    // a missed strobe hands back unknowns so every later compare trips
    b = (spoll_strobe === 1'b1) ? spoll_byte : 8'hxx;
    spoll_req_pin <= 1'b0;
    // low spacing between polls
    repeat (2) @(posedge pclk);
  endtask
endmodule

// ==== tb/calsr_top_tb.sv ====
`timescale 1ns/1ps
`include "calsr_map.svh"

module calsr_top_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic spoll_req_pin, srq, spoll_strobe;
  logic [7:0] paddr, spoll_byte, pb;
  logic [31:0] pwdata, prdata, v;
  logic [31:0] codes [6];
  int fails, n_tests;

  calsr_top calsr_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .spoll_req_pin(spoll_req_pin), .srq(srq), .spoll_byte(spoll_byte),
    .spoll_strobe(spoll_strobe));
  calsr_host_model calsr_host_model_i (.pclk(pclk), .spoll_req_pin(spoll_req_pin),
    .spoll_strobe(spoll_strobe), .spoll_byte(spoll_byte));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // ==========================================================
  // compares and bus tasks
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) chk1(pready, 1'b1);
    v = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk32(v, exp);
  endtask

  task automatic wait_poll(input logic [7:0] m);
    int n;
    n = 0;
    do begin
      calsr_host_model_i.poll(pb);
      n++;
    end while ((pb & m) == 8'h00 && n < 1500);
    chk1(|(pb & m), 1'b1);
  endtask

  // host must not send the next command while a step runs
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, `CALSR_OFF_STATUS, 32'h0);
      n++;
    end while (v[0] !== 1'b0 && n < 1000);
    chk1(v[0], 1'b0);
  endtask

  task automatic do_reset;
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask

  task automatic wrap_up;
    if (fails == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge pclk);
    fails++;
    wrap_up;
  end

  // ==========================================================
  // tests
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    codes = '{-102, -113, -222, 438, 439, 440};
    do_reset;
    rdc(`CALSR_OFF_SRE, 32'h0);
    rdc(`CALSR_OFF_ESE, 32'h0);
    rdc(`CALSR_OFF_STATUS, 32'h0);
    rdc(`CALSR_OFF_ERRQ, 32'h0);
    apb(1'b0, 8'h2c, 32'h0);
    chk1(e, 1'b1);
    // every parser error kind, oldest out first
    for (int k = 0; k < 6; k++) wr(`CALSR_OFF_ERR_RAISE, k + 1);
    rdc(`CALSR_OFF_STB, 32'h04);
    rdc(`CALSR_OFF_ESR, 32'h38);
    rdc(`CALSR_OFF_ESR, 32'h0);
    for (int k = 0; k < 6; k++) rdc(`CALSR_OFF_ERRQ, codes[k]);
    rdc(`CALSR_OFF_STB, 32'h0);
    rdc(`CALSR_OFF_ERRQ, 32'h0);
    // locked, out of order, busy and bad header
    wr(`CALSR_OFF_CTRL, 32'h1);
    wr(`CALSR_OFF_CMD, 32'h2);
    wr(`CALSR_OFF_CTRL, 32'h0);
    wr(`CALSR_OFF_CMD, 32'h3);
    wr(`CALSR_OFF_CMD, 32'h2);
    wr(`CALSR_OFF_CMD, 32'h2);
    wr(`CALSR_OFF_CMD, 32'h9);
    wait_idle;
    rdc(`CALSR_OFF_ERRQ, -221);
    rdc(`CALSR_OFF_ERRQ, 440);
    rdc(`CALSR_OFF_ERRQ, -200);
    rdc(`CALSR_OFF_ERRQ, -113);
    rdc(`CALSR_OFF_ESR, 32'h38);
    // ac self-cal with completion query appended
    wr(`CALSR_OFF_CMD, 32'h1);
    wr(`CALSR_OFF_CMD, 32'h4);
    rdc(`CALSR_OFF_STATUS, 32'h09);
    wait_poll(8'h10);
    rdc(`CALSR_OFF_OUTQ, 32'h31);
    calsr_host_model_i.poll(pb);
    chk1(pb[4], 1'b0);
    rdc(`CALSR_OFF_STATUS, 32'h0a);
    // completion command routed to event summary
    wr(`CALSR_OFF_ESE, 32'h1);
    wr(`CALSR_OFF_CMD, 32'h2);
    wr(`CALSR_OFF_CMD, 32'h5);
    wait_poll(8'h20);
    rdc(`CALSR_OFF_ESR, 32'h01);
    rdc(`CALSR_OFF_STB, 32'h0);
    // full procedure closes with the calculate step
    wr(`CALSR_OFF_CMD, 32'h3);
    rdc(`CALSR_OFF_STATUS, 32'h02);
    // service request on error available
    wr(`CALSR_OFF_SRE, 32'h4);
    rdc(`CALSR_OFF_SRE, 32'h4);
    wr(`CALSR_OFF_ERR_RAISE, 32'h3);
    repeat (3) @(posedge pclk);
    chk1(srq, 1'b1);
    wait_poll(8'h04);
    chk32({24'h0, pb}, 32'h44);
    wr(`CALSR_OFF_CMD, 32'h7);
    rdc(`CALSR_OFF_OUTQ, 32'h44);
    rdc(`CALSR_OFF_ERRQ, -222);
    repeat (3) @(posedge pclk);
    chk1(srq, 1'b0);
    // clear status empties queue and events
    wr(`CALSR_OFF_ERR_RAISE, 32'h1);
    wr(`CALSR_OFF_CMD, 32'h5);
    wr(`CALSR_OFF_CMD, 32'h6);
    rdc(`CALSR_OFF_ESR, 32'h0);
    rdc(`CALSR_OFF_ERRQ, 32'h0);
    rdc(`CALSR_OFF_STB, 32'h0);
    // event register query moves it to the output queue
    wr(`CALSR_OFF_ERR_RAISE, 32'h4);
    wr(`CALSR_OFF_CMD, 32'h8);
    rdc(`CALSR_OFF_OUTQ, 32'h08);
    rdc(`CALSR_OFF_ESR, 32'h0);
    rdc(`CALSR_OFF_ERRQ, 438);
    // ac constants lost over reset
    do_reset;
    rdc(`CALSR_OFF_STATUS, 32'h0);
    rdc(`CALSR_OFF_AC_CONST, 32'h0);
    rdc(`CALSR_OFF_SRE, 32'h0);
    wrap_up;
  end
endmodule
